// ==== inc/xio_pkg.sv ====
`default_nettype none
package xio_pkg;
  // fixed upper nibble of the slave address
  localparam logic [3:0] XIO_ADDR_FIXED = 4'h4;
  // strap-low 7-bit address 0100000, write byte 0x40
  localparam logic [6:0] XIO_ADDR_BASE = 7'h20;
  localparam logic [7:0] XIO_WRITE_BASE = 8'h40;
  // general call address, never answered
  localparam logic [6:0] XIO_GENERAL_CALL = 7'h00;
  // quasi-bidirectional pins come up high
  localparam logic [7:0] XIO_PORT_RESET = 8'hFF;
  // last bit index of the bit counter and synchroniser stage count
  localparam logic [2:0] XIO_LAST_BIT = 3'h7;
  localparam int XIO_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    XIO_IDLE = 3'b000,
    XIO_ADDR = 3'b001,
    XIO_AACK = 3'b010,
    XIO_WDAT = 3'b011,
    XIO_WACK = 3'b100,
    XIO_RDAT = 3'b101,
    XIO_RACK = 3'b110
  } xio_state_type;
endpackage
`default_nettype wire

// ==== design/xio_sync.sv ====
`default_nettype none
// two-flop synchroniser for one group of pins; first stage feeds only the second
module xio_sync import xio_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } xio_sync_type;
  xio_sync_type s_r;
  xio_sync_type s_nxt;

  // ============================================================
  // stages
  always_comb begin
    s_nxt.meta = i_async;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      // bus lines and port pins idle high: reset to ones so no false edge follows
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.sync;
endmodule
`default_nettype wire

// ==== design/xio_expander.sv ====
`default_nettype none
// How it works
// [RULE1] all straps low: write address byte 0x40 selects the device
// [RULE2] strap_low high: write 0x42, read 0x43; each strap step adds two
// [RULE3] all straps high: write 0x4E; read address is write plus one
// [RULE4] 7-bit address is 0100 then high, mid, low strap
// [RULE5] power-on reset release sets all state and bus machine to defaults
// [RULE6] no other reset besides power cycling
// [RULE7] byte bit 7 is the highest pin of the port, bit 0 the lowest
// [RULE8] bytes go in pairs: port zero then port one; each pair overwrites
// [RULE9] alert on any input pin edge; cleared by port access or pin return
// [RULE10] general call address is never acknowledged
// [RULE11] master transfers an even number of data bytes per transaction
module xio_expander import xio_pkg::*; (
  // clock and power-on reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // i2c bus, open drain
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // address straps
  input wire logic I_ADDRESS_STRAP_HIGH,
  input wire logic I_ADDRESS_STRAP_MID,
  input wire logic I_ADDRESS_STRAP_LOW,
  // quasi-bidirectional ports: pin level in, pull low when oe
  input wire logic [7:0] I_PORT_ZERO_PINS,
  input wire logic [7:0] I_PORT_ONE_PINS,
  output logic [7:0] O_PORT_ZERO_PINS,
  output logic [7:0] O_PORT_ONE_PINS,
  output logic [7:0] O_PORT_ZERO_OE,
  output logic [7:0] O_PORT_ONE_OE,
  // open-drain change alert, oe high pulls low
  output logic O_ALERT_OE
);
  typedef struct packed {
    xio_state_type st;
    logic scl_d;
    logic sda_d;
    logic [2:0] bitn;
    logic bit_seen;     // an address bit was clocked since the start
    logic [7:0] shreg;
    logic rw;
    logic pair_hi;      // next byte targets port one
    logic [7:0] hold0;  // port zero byte awaiting its partner on writes, port one sample on reads
    logic [7:0] lat0;
    logic [7:0] lat1;
    logic [15:0] ref_pins; // levels at last reset of the alert
    logic sda_oe;
    logic alert;
  } xio_state_r_type;

  xio_state_r_type s_r;
  xio_state_r_type s_nxt;
  logic scl_s;
  logic sda_s;
  logic [15:0] pins_s;
  logic [6:0] own_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] input_mask;

  // ============================================================
  // synchronisers for the bus lines and port pins outside the clock domain
  xio_sync #(.WIDTH(2)) u_bus_sync (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_async({I_SCL, I_SDA}),
    .o_sync({scl_s, sda_s})
  );
  xio_sync #(.WIDTH(16)) u_pin_sync (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_async({I_PORT_ONE_PINS, I_PORT_ZERO_PINS}),
    .o_sync(pins_s)
  );

  // ============================================================
  // address and bus conditions; straps are read live, not latched
  assign own_addr = {XIO_ADDR_FIXED, I_ADDRESS_STRAP_HIGH, I_ADDRESS_STRAP_MID,
                     I_ADDRESS_STRAP_LOW}; // [RULE4] [RULE1] [RULE2] [RULE3]
  assign scl_rise = scl_s & ~s_r.scl_d;
  assign scl_fall = ~scl_s & s_r.scl_d;
  assign start_c = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
  assign stop_c = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
  // a pin written high is an input; latched low pins are driven outputs
  assign input_mask = {s_r.lat1, s_r.lat0};

  // ============================================================
  // bus machine and alert
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_d = scl_s;
    s_nxt.sda_d = sda_s;
    // alert: set on any input edge, dropped when pins return [RULE9]
    if (((pins_s ^ s_r.ref_pins) & input_mask) != 16'h0000) begin
      s_nxt.alert = 1'b1;
    end else begin
      s_nxt.alert = 1'b0;
    end
    if (start_c) begin
      s_nxt.st = XIO_ADDR;
      s_nxt.bitn = 3'h0;
      s_nxt.bit_seen = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.pair_hi = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = XIO_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        XIO_IDLE: begin
          s_nxt.sda_oe = 1'b0;
        end
        XIO_ADDR: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], sda_s};
            s_nxt.bitn = s_r.bitn + 3'h1;
            s_nxt.bit_seen = 1'b1;
          end
          // the scl fall closing the start carries no bit; stale shreg must not decide
          if (scl_fall && s_r.bit_seen && s_r.bitn == 3'h0 &&
              s_r.shreg[7:1] != XIO_GENERAL_CALL &&
              s_r.shreg[7:1] == own_addr) begin // [RULE10] general call never matches
            s_nxt.rw = s_r.shreg[0];
            s_nxt.sda_oe = 1'b1;
            s_nxt.st = XIO_AACK;
          end else if (scl_fall && s_r.bit_seen && s_r.bitn == 3'h0 &&
                       s_r.shreg[7:1] != own_addr) begin
            s_nxt.st = XIO_IDLE; // not us, wait for next start
          end
        end
        XIO_AACK: begin
          if (scl_fall) begin
            s_nxt.bitn = 3'h0;
            if (s_r.rw) begin
              // sample both ports now; first byte is port zero [RULE8] [RULE7]
              s_nxt.shreg = pins_s[7:0];
              s_nxt.hold0 = pins_s[15:8];
              s_nxt.sda_oe = ~pins_s[7];
              s_nxt.st = XIO_RDAT;
            end else begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = XIO_WDAT;
            end
          end
        end
        XIO_WDAT: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], sda_s}; // msb first [RULE7]
            s_nxt.bitn = s_r.bitn + 3'h1;
          end
          if (scl_fall && s_r.bitn == 3'h0) begin
            s_nxt.sda_oe = 1'b1;
            s_nxt.st = XIO_WACK;
            if (!s_r.pair_hi) begin
              s_nxt.hold0 = s_r.shreg; // port zero waits for its partner [RULE8]
            end else begin
              s_nxt.lat0 = s_r.hold0; // pair complete: overwrite both [RULE8]
              s_nxt.lat1 = s_r.shreg;
              s_nxt.ref_pins = {s_r.shreg, s_r.hold0}; // write clears alert [RULE9]
            end
            s_nxt.pair_hi = ~s_r.pair_hi;
          end
        end
        XIO_WACK: begin
          if (scl_fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.bitn = 3'h0;
            s_nxt.st = XIO_WDAT;
          end
        end
        XIO_RDAT: begin
          if (scl_rise) begin
            s_nxt.bitn = s_r.bitn + 3'h1;
          end
          if (scl_fall) begin
            if (s_r.bitn == 3'h0) begin
              s_nxt.sda_oe = 1'b0; // release for master ack
              s_nxt.st = XIO_RACK;
            end else begin
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.shreg[6];
            end
          end
        end
        XIO_RACK: begin
          if (scl_rise) begin
            // read clears alert at the ack rising edge [RULE9]
            s_nxt.ref_pins = pins_s;
            s_nxt.rw = sda_s; // reuse as nack flag
          end
          if (scl_fall) begin
            s_nxt.bitn = 3'h0;
            if (s_r.rw) begin
              s_nxt.st = XIO_IDLE; // master nack ends the read
              s_nxt.rw = 1'b1;
            end else begin
              s_nxt.pair_hi = ~s_r.pair_hi;
              // next byte: port one, else a fresh sample of port zero [RULE8]
              if (!s_r.pair_hi) begin
                s_nxt.shreg = s_r.hold0;
                s_nxt.sda_oe = ~s_r.hold0[7];
              end else begin
                s_nxt.shreg = pins_s[7:0];
                s_nxt.hold0 = pins_s[15:8];
                s_nxt.sda_oe = ~pins_s[7];
              end
              s_nxt.rw = 1'b1;
              s_nxt.st = XIO_RDAT;
            end
          end
        end
        default: begin
          s_nxt.st = XIO_IDLE;
        end
      endcase
    end
  end

  // the only reset is power-on; no command or pin resets the block [RULE5] [RULE6]
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      s_r <= '{st: XIO_IDLE, scl_d: 1'b1, sda_d: 1'b1, bitn: 3'h0, bit_seen: 1'b0,
               shreg: 8'h00, rw: 1'b0, pair_hi: 1'b0, hold0: XIO_PORT_RESET,
               lat0: XIO_PORT_RESET, lat1: XIO_PORT_RESET,
               ref_pins: {2{XIO_PORT_RESET}}, sda_oe: 1'b0, alert: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // outputs from flops or inverted flops; drive values tied low
  assign O_SDA = 1'b0;
  assign O_SDA_OE = s_r.sda_oe;
  assign O_PORT_ZERO_PINS = 8'h00;
  assign O_PORT_ONE_PINS = 8'h00;
  assign O_PORT_ZERO_OE = ~s_r.lat0;
  assign O_PORT_ONE_OE = ~s_r.lat1;
  assign O_ALERT_OE = s_r.alert;

  // ============================================================
  // checks
  a_addr_ack: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s_r.st == XIO_ADDR && s_nxt.st == XIO_AACK) |-> s_r.shreg[7:1] == own_addr) // [RULE4]
    else $error("ack given to foreign address");
  a_gc_nack: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s_r.st == XIO_ADDR && s_r.shreg[7:1] == XIO_GENERAL_CALL) |=> s_r.st != XIO_AACK) // [RULE10]
    else $error("general call acknowledged");
  a_base_addr: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (!I_ADDRESS_STRAP_HIGH && !I_ADDRESS_STRAP_MID && !I_ADDRESS_STRAP_LOW)
    |-> {own_addr, 1'b0} == XIO_WRITE_BASE) // [RULE1]
    else $error("base write address wrong");
  a_step_addr: assert property (@(posedge I_CLK) disable iff (I_RESET)
    {own_addr, 1'b1} == 8'h41 + {4'h0, I_ADDRESS_STRAP_HIGH, I_ADDRESS_STRAP_MID,
    I_ADDRESS_STRAP_LOW, 1'b0}) // [RULE2]
    else $error("read address step wrong");
  a_top_addr: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_ADDRESS_STRAP_HIGH && I_ADDRESS_STRAP_MID && I_ADDRESS_STRAP_LOW)
    |-> {own_addr, 1'b0} == 8'h4E) // [RULE3]
    else $error("top write address wrong");
  a_pair_hold: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s_r.st == XIO_WDAT && !s_r.pair_hi) |=> $stable(s_r.lat1)) // [RULE8]
    else $error("port one changed mid pair");
  a_alert_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (((pins_s ^ s_r.ref_pins) & input_mask) != 16'h0000) |=> O_ALERT_OE) // [RULE9]
    else $error("alert missed an input edge");
  a_pair_lat: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $changed(s_r.lat0) |-> $past(s_r.pair_hi) && !s_r.pair_hi) // [RULE8]
    else $error("port zero latched off pair");
  c_write_pair: cover property (@(posedge I_CLK) $changed(s_r.lat1));
  c_read_ack: cover property (@(posedge I_CLK) s_r.st == XIO_RACK);
  c_alert: cover property (@(posedge I_CLK) $rose(O_ALERT_OE));
endmodule
`default_nettype wire

// ==== test/xio_master.sv ====
`default_nettype none
// ==========
// bus master model; 1 on an output means the line is released
module xio_master_model (
  // clock and sensed data line
  input wire logic i_clk,
  input wire logic i_sda_line,
  // open-drain drive levels
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released, as the pull-ups leave it
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // moves land on falling edges, well away from the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // sda falls while scl is high; also serves as a repeated start
  task automatic start();
    tick(1);
    o_sda = 1'b1;
    tick(3);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
  endtask
  // sda rises while scl is high
  task automatic stop();
    tick(1);
    o_sda = 1'b0;
    tick(3);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask
  // nine bits msb first, 4 clocks low then 4 high, sampled mid-high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      o_sda = tx[i];
      tick(3);
      o_scl = 1'b1;
      tick(2);
      q[i] = i_sda_line;
      tick(2);
      o_scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== test/tb_xio_expander.sv ====
`default_nettype none
module tb_xio_expander import xio_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, m_scl, m_sda, sda_line, sda_oe, alert_oe;
  logic [2:0] st;
  logic [7:0] e0, e1, oe0, oe1, b0, wa;
  logic sda_o;
  logic [7:0] po0, po1;
  logic [8:0] rx;
  logic [15:0] exp_q[$];
  int failures, tests_run, seed;
  // ==========
  // wiring: both lines are wired-and of every driver
  // a driven line shows the driven value, so a wrong drive value shows up on the bus
  assign sda_line = m_sda & (~sda_oe | sda_o);
  xio_master_model m (.i_clk(clk), .i_sda_line(sda_line), .o_scl(m_scl), .o_sda(m_sda));
  xio_expander uut (.I_CLK(clk), .I_RESET(rst), .I_SCL(m_scl), .I_SDA(sda_line),
    .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_ADDRESS_STRAP_HIGH(st[2]),
    .I_ADDRESS_STRAP_MID(st[1]), .I_ADDRESS_STRAP_LOW(st[0]),
    .I_PORT_ZERO_PINS(e0 & (~oe0 | po0)), .I_PORT_ONE_PINS(e1 & (~oe1 | po1)),
    .O_PORT_ZERO_PINS(po0), .O_PORT_ONE_PINS(po1), .O_PORT_ZERO_OE(oe0),
    .O_PORT_ONE_OE(oe1), .O_ALERT_OE(alert_oe));
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // address phase; an ack is a low ninth bit
  task automatic addr(input logic [7:0] a, input logic ack);
    m.start();
    m.xfer({a, 1'b1}, rx);
    check({15'h0, rx[0]}, {15'h0, ~ack});
  endtask
  // read one pair, master nacks the second byte
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    addr(a, 1'b1);
    m.xfer(9'h1FE, rx);
    b0 = rx[8:1];
    m.xfer(9'h1FF, rx);
    m.stop();
    check({rx[8:1], b0}, want);
  endtask
  // two pairs, second swapped; a note only where the drive must change
  task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
      input logic odd);
    addr(a, 1'b1);
    for (int p = 0; p < 2; p++) begin
      m.xfer({d0, 1'b1}, rx);
      if (~{d1, d0} !== {oe1, oe0}) exp_q.push_back(~{d1, d0});
      m.xfer({d1, 1'b1}, rx);
      check({15'h0, rx[0]}, 16'h0);
      {d0, d1} = {d1, d0};
    end
    if (odd) m.xfer({d0, 1'b1}, rx); // lone byte must be dropped
    m.stop();
  endtask
  // alert settles within a few clocks after a pin edge
  task automatic ck_alert(input logic want);
    repeat (10) @(negedge clk);
    check({15'h0, alert_oe}, {15'h0, want});
  endtask
  // watcher: each port drive change takes the oldest note
  initial begin
    @(negedge rst);
    forever begin
      @(oe0 or oe1);
      #1;
      check({oe1, oe0}, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
    end
  end
  // watchdog, well past the expected 0.31 ms run
  initial begin
    #2_000_000;
    failures++;
    summarize();
  end
  // ==========
  // main sequence
  initial begin
    seed = 32'h0000_313d;
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    st = 3'h0;
    e0 = 8'hFF;
    e1 = 8'hFF;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int s = 0; s < 8; s++) begin
      st = s[2:0];
      addr(XIO_WRITE_BASE | {4'h0, st ^ 3'h5, 1'b0}, 1'b0);
      m.stop();
      rd(XIO_WRITE_BASE | {4'h0, st, 1'b1}, 16'hFFFF);
      wr(XIO_WRITE_BASE | {4'h0, st, 1'b0}, XIO_PORT_RESET, XIO_PORT_RESET, 1'b0);
    end
    addr({XIO_GENERAL_CALL, 1'b0}, 1'b0);
    m.stop();
    $display("test decode done");
    st = 3'($random(seed));
    wa = XIO_WRITE_BASE | {4'h0, st, 1'b0};
    wr(wa, 8'($random(seed)), 8'($random(seed)), 1'b1);
    $display("test write done");
    wr(wa, 8'hFF, 8'hFF, 1'b0);
    e0 = 8'($random(seed)) & 8'hFE;
    e1 = 8'($random(seed));
    ck_alert(1'b1);
    rd(wa | 8'h01, {e1, e0});
    ck_alert(1'b0);
    e1 = ~e1;
    ck_alert(1'b1);
    e1 = ~e1;
    ck_alert(1'b0);
    $display("test read alert done");
    e0 = 8'hFF;
    e1 = 8'hFF;
    ck_alert(1'b1);
    wr(wa, 8'h00, 8'h5A, 1'b0);
    ck_alert(1'b0); // a write clears the alert
    m.start();
    repeat (12) @(negedge clk);
    exp_q.push_back(16'h0000);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check({14'h0, sda_oe, alert_oe}, 16'h0);
    rst = 1'b0;
    m.stop();
    repeat (4) @(negedge clk);
    wr(wa, 8'h3C, 8'h3C, 1'b0);
    $display("test reset done");
    repeat (20) @(negedge clk);
    check(16'(exp_q.size()), 16'h0);
    summarize();
  end
endmodule
`default_nettype wire
